// *** rtl/sfe_pkg.sv ***
package sfe_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int SLEEP_ENTRY_DELAY_NS = 3000;
	localparam int WAKE_DELAY_NS = 3000;
	localparam int WAKE_ID_DELAY_NS = 3000;
	// Least times round up to whole cycles
	localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_CYC = (WAKE_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_ID_CYC = (WAKE_ID_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int BLK32_TIME_US = 150000;
	localparam int BLK64_TIME_US = 250000;
	localparam int CHIP_TIME_US = 1000000;
	localparam int BLK32_CYC_DEF = BLK32_TIME_US * CLK_MHZ;
	localparam int BLK64_CYC_DEF = BLK64_TIME_US * CLK_MHZ;
	localparam int CHIP_CYC_DEF = CHIP_TIME_US * CLK_MHZ;

	// ----------------------------------------
	// Serial opcodes and frame lengths
	// ----------------------------------------
	localparam logic [7:0] OP_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_STATUS = 8'h05;
	localparam logic [7:0] OP_BLK32 = 8'h52;
	localparam logic [7:0] OP_BLK64 = 8'hd8;
	localparam logic [7:0] OP_CHIP_A = 8'h60;
	localparam logic [7:0] OP_CHIP_B = 8'hc7;
	localparam logic [7:0] OP_SLEEP = 8'hb9;
	localparam logic [7:0] OP_WAKE_ID = 8'hab;
	localparam logic [7:0] OP_PAIR_ID = 8'h90;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [5:0] OP_BITS = 6'h08;
	localparam logic [5:0] ADDR_FRAME_BITS = 6'h20;

	// Identification bytes; values are arbitrary
	localparam logic [7:0] MAKER_ID = 8'h5a;
	localparam logic [7:0] PART_ID = 8'ha5;

	// Serial status byte layout
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_LATCH_BIT = 1;

	// ----------------------------------------
	// APB register map
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_WIPE_ADDR = 8'h08;
	localparam int CTRL_BP_LSB = 0;
	localparam int CTRL_INV_BIT = 5;
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam int STS_ACTIVE_BIT = 0;
	localparam int STS_LATCH_BIT = 1;
	localparam int STS_ASLEEP_BIT = 2;
	localparam int STS_WAKING_BIT = 3;

	// Pin vector order {si, sclk, cs_n}; select idles high
	localparam logic [2:0] PIN_RST = 3'h1;

	typedef enum logic [1:0] {WK_BLK32, WK_BLK64, WK_CHIP} sfe_wipe_kind_t;

	typedef struct packed {
		logic si_lvl;
		logic cs_lvl;
		logic cs_rise;
		logic sclk_rise;
		logic sclk_fall;
	} sfe_pin_ev_t;

	typedef struct packed {
		logic start;
		sfe_wipe_kind_t kind;
		logic [23:0] base;
	} sfe_wipe_req_t;

endpackage : sfe_pkg

// *** rtl/sfe_pin_sync.sv ***
`timescale 1ns/10ps
module sfe_pin_sync
	import sfe_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Serial pins from the host
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	// Synchronised levels and edges
	output sfe_pin_ev_t ev
);

	logic [2:0] pins;
	logic [2:0] meta_ff;
	logic [2:0] sync_ff;
	logic [2:0] last_ff;

	assign pins = {si, sclk, cs_n};

	// ----------------------------------------
	// Two-stage synchroniser plus edge history
	// ----------------------------------------
	for (genvar i = 0; i < 3; i++) begin : g_pin
		always_ff @(posedge clk) begin
			if (reset) begin
				meta_ff[i] <= PIN_RST[i];
				sync_ff[i] <= PIN_RST[i];
				last_ff[i] <= PIN_RST[i];
			end else begin
				meta_ff[i] <= pins[i];
				sync_ff[i] <= meta_ff[i];
				last_ff[i] <= sync_ff[i];
			end
		end
	end

	// Edges are taken from the second stage only, never the first
	assign ev.si_lvl = sync_ff[2];
	assign ev.cs_lvl = sync_ff[0];
	assign ev.cs_rise = sync_ff[0] & ~last_ff[0];
	assign ev.sclk_rise = sync_ff[1] & ~last_ff[1];
	assign ev.sclk_fall = ~sync_ff[1] & last_ff[1];

endmodule : sfe_pin_sync

// *** rtl/sfe_flash_cmd.sv ***
`timescale 1ns/10ps
module sfe_flash_cmd
	import sfe_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter int BLK32_CYC = BLK32_CYC_DEF,
	parameter int BLK64_CYC = BLK64_CYC_DEF,
	parameter int CHIP_CYC = CHIP_CYC_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Serial link from the host
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// Array side
	output sfe_wipe_req_t wipe,
	output logic cycle_active_flag,
	output logic asleep,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	if (ADDR_W < 17 || ADDR_W > 24) begin : g_bad_addr
		$error("ADDR_W must lie between 17 and 24");
	end
	if (BLK32_CYC < 1 || BLK64_CYC < 1 || CHIP_CYC < 1) begin : g_bad_time
		$error("Erase cycle counts must be at least one");
	end

	typedef enum logic [1:0] {MD_STANDBY, MD_ENTERING, MD_SLEEP, MD_WAKING} sfe_mode_t;

	sfe_pin_ev_t ev;
	sfe_mode_t mode_ff;
	sfe_wipe_req_t wipe_ff;
	logic [5:0] bit_cnt_ff;
	logic [31:0] shift_ff, wipe_cnt_ff, prdata_ff;
	logic [7:0] op_ff, op_now, status_byte;
	logic [15:0] out_sh_ff, mode_cnt_ff;
	logic [4:0] protect_level_bits;
	logic [23:0] last_addr_ff;
	logic out_act_ff, so_ff, so_oe_ff, write_latch_flag, rst_armed_ff;
	logic protect_invert_bit, asleep_ff, pready_ff, pslverr_ff;
	logic awake, blk_op, blk_locked, chip_ok, go_blk, go_chip, go_sleep, go_wake, go_reset, apb_hit;

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	sfe_pin_sync u_sync (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .si(si), .ev(ev));

	// Block lock map: low three protect bits pick 2^(n-1) 64 KB blocks, bit 3 picks bottom
	function automatic logic block_locked(input logic [23:0] a, input logic [4:0] bp, input logic inv);
		int nb;
		int blk;
		int sz;
		logic hit;
		nb = 1 << (ADDR_W - 16);
		blk = int'(a[23:16]) & (nb - 1);
		sz = (bp[2:0] == 3'h0) ? 0 : (1 << (int'(bp[2:0]) - 1));
		if (sz > nb) begin
			sz = nb;
		end
		hit = bp[3] ? (blk < sz) : (blk >= nb - sz);
		return hit ^ inv;
	endfunction : block_locked

	// ----------------------------------------
	// Frame decode at select release
	// ----------------------------------------
	assign op_now = {shift_ff[6:0], ev.si_lvl};
	assign awake = (mode_ff == MD_STANDBY);
	assign blk_op = (op_ff == OP_BLK32) || (op_ff == OP_BLK64);
	assign blk_locked = block_locked(shift_ff[23:0], protect_level_bits, protect_invert_bit);
	assign chip_ok = (protect_level_bits[2:0] == 3'h0 && !protect_invert_bit) ||
		(protect_level_bits[2:0] == 3'h7 && protect_invert_bit);
	// Exact frame lengths guard against early or late select release; wake alone also accepts frames of 32 bits or more
	assign go_blk = ev.cs_rise && awake && bit_cnt_ff == ADDR_FRAME_BITS && blk_op &&
		write_latch_flag && !cycle_active_flag && !blk_locked;
	assign go_chip = ev.cs_rise && awake && bit_cnt_ff == OP_BITS && chip_ok &&
		(op_ff == OP_CHIP_A || op_ff == OP_CHIP_B) && write_latch_flag && !cycle_active_flag;
	assign go_sleep = ev.cs_rise && awake && bit_cnt_ff == OP_BITS && op_ff == OP_SLEEP &&
		!cycle_active_flag;
	assign go_wake = ev.cs_rise && mode_ff == MD_SLEEP && op_ff == OP_WAKE_ID &&
		(bit_cnt_ff == OP_BITS || bit_cnt_ff >= ADDR_FRAME_BITS);
	assign go_reset = ev.cs_rise && bit_cnt_ff == OP_BITS && op_ff == OP_RST && rst_armed_ff &&
		!cycle_active_flag;

	// Bit counter and input shifter; only the counter is cleared whenever select is high
	always_ff @(posedge clk) begin
		if (reset || ev.cs_lvl) begin
			bit_cnt_ff <= 6'h00;
		end else if (ev.sclk_rise && bit_cnt_ff != 6'h3f) begin
			bit_cnt_ff <= bit_cnt_ff + 6'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			shift_ff <= 32'h0;
			op_ff <= 8'h00;
		end else if (ev.sclk_rise && !ev.cs_lvl) begin
			shift_ff <= {shift_ff[30:0], ev.si_lvl};
			if (bit_cnt_ff == OP_BITS - 6'h01) begin
				op_ff <= op_now;
			end
		end
	end

	// Reset enable arms only the very next frame
	always_ff @(posedge clk) begin
		if (reset) begin
			rst_armed_ff <= 1'b0;
		end else if (ev.cs_rise) begin
			rst_armed_ff <= (bit_cnt_ff == OP_BITS) && (op_ff == OP_RST_EN);
		end
	end

	// ----------------------------------------
	// Write latch and self-timed erase
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset || go_reset) begin
			write_latch_flag <= 1'b0;
		end else if (go_blk || go_chip) begin
			write_latch_flag <= 1'b0;
		end else if (ev.cs_rise && awake && bit_cnt_ff == OP_BITS && op_ff == OP_LATCH_SET &&
			!cycle_active_flag) begin
			write_latch_flag <= 1'b1;
		end
	end

	// The active flag simply tracks the remaining cycle count
	always_ff @(posedge clk) begin
		if (reset) begin
			cycle_active_flag <= 1'b0;
			wipe_cnt_ff <= 32'h0;
		end else if (go_blk || go_chip) begin
			cycle_active_flag <= 1'b1;
			wipe_cnt_ff <= go_chip ? 32'(CHIP_CYC) : (op_ff == OP_BLK32) ? 32'(BLK32_CYC) : 32'(BLK64_CYC);
		end else if (cycle_active_flag) begin
			wipe_cnt_ff <= wipe_cnt_ff - 32'h1;
			if (wipe_cnt_ff == 32'h1) begin
				cycle_active_flag <= 1'b0;
			end
		end
	end

	// Array request: one-cycle start with block-aligned base
	always_ff @(posedge clk) begin
		if (reset) begin
			wipe_ff <= '{start: 1'b0, kind: WK_BLK32, base: 24'h0};
			last_addr_ff <= 24'h0;
		end else begin
			wipe_ff.start <= go_blk || go_chip;
			if (go_chip) begin
				wipe_ff.kind <= WK_CHIP;
				wipe_ff.base <= 24'h0;
			end else if (go_blk && op_ff == OP_BLK32) begin
				wipe_ff.kind <= WK_BLK32;
				wipe_ff.base <= {shift_ff[23:15], 15'h0};
				last_addr_ff <= shift_ff[23:0];
			end else if (go_blk) begin
				wipe_ff.kind <= WK_BLK64;
				wipe_ff.base <= {shift_ff[23:16], 16'h0};
				last_addr_ff <= shift_ff[23:0];
			end
		end
	end

	// ----------------------------------------
	// Power mode and its delays
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_ff <= MD_STANDBY;
			mode_cnt_ff <= 16'h0;
			asleep_ff <= 1'b0;
		end else begin
			asleep_ff <= (mode_ff == MD_SLEEP);
			case (mode_ff)
				MD_STANDBY: begin
					if (go_sleep) begin
						mode_ff <= MD_ENTERING;
						mode_cnt_ff <= 16'(SLEEP_ENTRY_CYC);
					end
				end
				MD_ENTERING: begin
					mode_cnt_ff <= mode_cnt_ff - 16'h1;
					if (mode_cnt_ff == 16'h1) begin
						mode_ff <= MD_SLEEP;
					end
				end
				MD_SLEEP: begin
					if (go_reset) begin
						mode_ff <= MD_STANDBY;
					end else if (go_wake) begin
						mode_ff <= MD_WAKING;
						mode_cnt_ff <= (bit_cnt_ff == OP_BITS) ? 16'(WAKE_CYC) : 16'(WAKE_ID_CYC);
					end
				end
				MD_WAKING: begin
					mode_cnt_ff <= mode_cnt_ff - 16'h1;
					if (mode_cnt_ff == 16'h1) begin
						mode_ff <= MD_STANDBY;
					end
				end
				default: begin
					mode_ff <= MD_STANDBY;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Serial read output
	// ----------------------------------------
	always_comb begin
		status_byte = 8'h00;
		status_byte[ST_ACTIVE_BIT] = cycle_active_flag;
		status_byte[ST_LATCH_BIT] = write_latch_flag;
	end

	// Load the answer on the rising edge that completes its header; a 16-bit ring repeats it
	always_ff @(posedge clk) begin
		if (reset || ev.cs_lvl) begin
			out_act_ff <= 1'b0;
			out_sh_ff <= 16'h0;
		end else if (ev.sclk_rise) begin
			if (awake && bit_cnt_ff == OP_BITS - 6'h01 && op_now == OP_STATUS) begin
				out_act_ff <= 1'b1;
				out_sh_ff <= {status_byte, status_byte};
			end else if (bit_cnt_ff == ADDR_FRAME_BITS - 6'h01 && !cycle_active_flag &&
				(awake || mode_ff == MD_SLEEP) && op_ff == OP_WAKE_ID) begin
				out_act_ff <= 1'b1;
				out_sh_ff <= {PART_ID, PART_ID};
			end else if (bit_cnt_ff == ADDR_FRAME_BITS - 6'h01 && awake && !cycle_active_flag &&
				op_ff == OP_PAIR_ID) begin
				out_act_ff <= 1'b1;
				out_sh_ff <= ev.si_lvl ? {PART_ID, MAKER_ID} : {MAKER_ID, PART_ID};
			end
		end else if (ev.sclk_fall && out_act_ff) begin
			out_sh_ff <= {out_sh_ff[14:0], out_sh_ff[15]};
		end
	end

	// Bits change only on falling clock edges, MSB first
	always_ff @(posedge clk) begin
		if (reset || ev.cs_lvl) begin
			so_ff <= 1'b0;
			so_oe_ff <= 1'b0;
		end else if (ev.sclk_fall && out_act_ff) begin
			so_ff <= out_sh_ff[15];
			so_oe_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// APB slave: one wait state, errors on unmapped offsets
	// ----------------------------------------
	assign apb_hit = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_WIPE_ADDR);

	always_ff @(posedge clk) begin
		if (reset) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else if (psel && penable && !pready_ff) begin
			pready_ff <= 1'b1;
			pslverr_ff <= !apb_hit;
			prdata_ff <= 32'h0;
			if (!pwrite) begin
				if (paddr == REG_CTRL) begin
					prdata_ff[CTRL_INV_BIT:CTRL_BP_LSB] <= {protect_invert_bit, protect_level_bits};
				end else if (paddr == REG_STATUS) begin
					prdata_ff[STS_ACTIVE_BIT] <= cycle_active_flag;
					prdata_ff[STS_LATCH_BIT] <= write_latch_flag;
					prdata_ff[STS_ASLEEP_BIT] <= (mode_ff == MD_SLEEP);
					prdata_ff[STS_WAKING_BIT] <= (mode_ff == MD_WAKING);
				end else if (paddr == REG_WIPE_ADDR) begin
					prdata_ff[23:0] <= last_addr_ff;
				end
			end
		end else begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	// Protection bits change only at the completing edge of a write
	always_ff @(posedge clk) begin
		if (reset) begin
			{protect_invert_bit, protect_level_bits} <= CTRL_RST;
		end else if (psel && penable && pready_ff && pwrite && paddr == REG_CTRL) begin
			{protect_invert_bit, protect_level_bits} <= pwdata[CTRL_INV_BIT:CTRL_BP_LSB];
		end
	end

	assign so = so_ff;
	assign so_oe = so_oe_ff;
	assign wipe = wipe_ff;
	assign asleep = asleep_ff;
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_wipe_needs_latch: assert property (@(posedge clk) disable iff (reset)
		wipe_ff.start |-> $past(write_latch_flag)) else $error("Erase started without write latch");
	a_wipe_after_frame: assert property (@(posedge clk) disable iff (reset)
		wipe_ff.start |-> $past(ev.cs_rise)) else $error("Erase started without select release");
	a_wipe_sets_busy: assert property (@(posedge clk) disable iff (reset)
		wipe_ff.start |-> cycle_active_flag ##1 cycle_active_flag) else $error("Active flag not held");
	a_latch_clear: assert property (@(posedge clk) disable iff (reset)
		$rose(cycle_active_flag) |-> !write_latch_flag) else $error("Latch not cleared by erase");
	a_blk_lock: assert property (@(posedge clk) disable iff (reset)
		wipe_ff.start && wipe_ff.kind != WK_CHIP |-> !$past(blk_locked)) else $error("Locked block erased");
	a_chip_prot: assert property (@(posedge clk) disable iff (reset)
		wipe_ff.start && wipe_ff.kind == WK_CHIP |-> $past(chip_ok)) else $error("Chip erase while protected");
	a_sleep_reject: assert property (@(posedge clk) disable iff (reset)
		cycle_active_flag && awake && ev.cs_rise |=> mode_ff == MD_STANDBY) else $error("Sleep during cycle");
	a_sleep_deaf: assert property (@(posedge clk) disable iff (reset)
		mode_ff == MD_SLEEP && ev.cs_rise |=> !wipe_ff.start ##1 !wipe_ff.start) else $error("Erase while asleep");
	a_so_release: assert property (@(posedge clk) disable iff (reset)
		ev.cs_lvl |=> !so_oe_ff) else $error("Output driven with select high");

	c_blk_wipe: cover property (@(posedge clk) disable iff (reset) wipe_ff.start && wipe_ff.kind == WK_BLK64);
	c_chip_wipe: cover property (@(posedge clk) disable iff (reset) wipe_ff.start && wipe_ff.kind == WK_CHIP);
	c_sleep: cover property (@(posedge clk) disable iff (reset) $rose(asleep_ff));
	c_id_out: cover property (@(posedge clk) disable iff (reset) $rose(so_oe_ff));

endmodule : sfe_flash_cmd

// *** bench/sfe_host_model.sv ***
`timescale 1ns/10ps
module sfe_host_model
	import sfe_pkg::*;
(
	// Serial link to the flash
	output logic cs_n,
	output logic sclk,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	// Select idles high; the clock stands low between frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end

	// ----------
	// Frame: n bits out MSB first, then nrd bits read back
	// ----------
	task automatic frame(input logic [31:0] w, input int n, input int nrd, output logic [15:0] rd,
		output logic oe);
		rd = 16'h0000;
		oe = 1'b0;
		// Pins move by non-blocking assignment so a change on a clock edge never races the first flop
		cs_n <= 1'b0;
		#80;
		for (int i = n - 1; i >= 0; i--) begin
			si <= w[i];
			#80 sclk <= 1'b1;
			#80 sclk <= 1'b0;
		end
		for (int i = 0; i < nrd; i++) begin
			si <= ~si;
			#80 sclk <= 1'b1;
			// Sample mid-high; a released line reads as the inverse of its last level
			#40 rd = {rd[14:0], so_oe ? so : ~so};
			oe = oe | so_oe;
			#40 sclk <= 1'b0;
		end
		// Select rises right after the last bit, then stays high a while
		#80 cs_n <= 1'b1;
		si <= ~si;
		#320;
	endtask : frame
endmodule : sfe_host_model

// *** bench/sfe_flash_cmd_tb_top.sv ***
`timescale 1ns/10ps
module sfe_flash_cmd_tb_top
	import sfe_pkg::*;
;
	// Short erase times keep the run brief; status reads still fit inside
	localparam int C32 = 400;
	localparam int C64 = 500;
	localparam int CCH = 600;
	localparam logic [5:0] PROT [5] = '{6'h01, 6'h07, 6'h20, 6'h27, 6'h00};
	localparam logic [4:0] CHIP_OK = 5'b11000;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, e, oe;
	logic cs_n, sclk, si, so, so_oe, cycle_active_flag, asleep;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] rd;
	logic [23:0] a;
	logic [25:0] exp_q[$];
	sfe_wipe_req_t wipe;
	int n_errors, compares, seed, n_act, dur_exp;

	sfe_flash_cmd #(.BLK32_CYC(C32), .BLK64_CYC(C64), .CHIP_CYC(CCH)) i_sfe_flash_cmd (.clk(clk),
		.reset(reset), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe), .wipe(wipe),
		.cycle_active_flag(cycle_active_flag), .asleep(asleep), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	sfe_host_model i_sfe_host_model (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));

	initial clk = 1'b0;
	always #10 clk = ~clk;

	// ----------
	// Shared tasks
	// ----------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		chk(32'(pready), 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic reg_chk(input logic [7:0] ad, input logic [31:0] exp, input logic err);
		apb(1'b0, ad, 32'h0);
		chk(q, exp);
		chk(32'(e), 32'(err));
	endtask : reg_chk

	task automatic tx(input logic [31:0] w, input int n, input int nrd);
		i_sfe_host_model.frame(w, n, nrd, rd, oe);
	endtask : tx

	// Expected starts are noted before the frame goes out
	task automatic erase(input logic [7:0] op, input logic [23:0] ad, input logic latch, input logic ok,
		input logic [1:0] k, input logic [23:0] b);
		if (ok) exp_q.push_back({k, b});
		if (latch) tx(32'(OP_LATCH_SET), 8, 0);
		if (op == OP_CHIP_A || op == OP_CHIP_B) tx(32'(op), 8, 0);
		else tx({op, ad}, 32, 0);
		@(posedge clk);
		chk(32'(cycle_active_flag), 32'(ok));
	endtask : erase

	task automatic idle;
		for (int i = 0; i < 2000 && cycle_active_flag !== 1'b0; i++) @(posedge clk);
		chk(32'(cycle_active_flag), 32'h0);
	endtask : idle

	task automatic sleep;
		tx(32'(OP_SLEEP), 8, 0);
		repeat (SLEEP_ENTRY_CYC) @(posedge clk);
	endtask : sleep

	task summarize;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	// Monitor: every erase start takes the oldest note; the busy span is timed
	always @(posedge clk) begin
		if (reset === 1'b0 && wipe.start === 1'b1) begin
			if (exp_q.size() == 0) chk(32'h1, 32'h0);
			else begin
				chk(32'({wipe.kind, wipe.base}), 32'(exp_q[0]));
				dur_exp = exp_q[0][25:24] == 2'h0 ? C32 : exp_q[0][25:24] == 2'h1 ? C64 : CCH;
				void'(exp_q.pop_front());
			end
		end
		if (cycle_active_flag === 1'b1) n_act++;
		else if (n_act != 0) begin
			chk(32'(n_act), 32'(dur_exp));
			n_act = 0;
		end
	end

	// Watchdog at one millisecond, about four times the expected run
	initial begin
		#1000000;
		n_errors++;
		summarize();
	end

	// ----------
	// Main sequence
	// ----------
	initial begin
		seed = 43;
		reset <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		reg_chk(REG_CTRL, 32'h0, 1'b0);
		reg_chk(REG_STATUS, 32'h0, 1'b0);
		reg_chk(8'h0c, 32'h0, 1'b1);
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			a = 24'($random(seed)) & 24'h02ffff;
			erase(OP_BLK64, a, 1'b1, 1'b1, 2'h1, a & 24'hff0000);
			tx(32'(OP_STATUS), 8, 8);
			chk(32'(rd[7:0]), 32'h1);
			idle();
			erase(OP_BLK32, a, 1'b1, 1'b1, 2'h0, a & 24'hff8000);
			idle();
		end
		$display("test block erase done");
		erase(OP_BLK64, a, 1'b0, 1'b0, 2'h1, 24'h0);
		reg_chk(REG_STATUS, 32'h0, 1'b0);
		tx(32'(OP_LATCH_SET), 8, 0);
		tx({1'b0, OP_BLK64, a[23:1]}, 31, 0);
		reg_chk(REG_STATUS, 32'h2, 1'b0);
		$display("test refusals done");
		apb(1'b1, REG_CTRL, 32'h1);
		reg_chk(REG_CTRL, 32'h1, 1'b0);
		erase(OP_BLK64, 24'h031234, 1'b1, 1'b0, 2'h1, 24'h0);
		erase(OP_BLK32, 24'h02abcd, 1'b1, 1'b1, 2'h0, 24'h028000);
		reg_chk(REG_WIPE_ADDR, 32'h0002abcd, 1'b0);
		idle();
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, REG_CTRL, {26'h0, PROT[i]});
			erase(i[0] ? OP_CHIP_B : OP_CHIP_A, 24'h0, 1'b1, CHIP_OK[i], 2'h2, 24'h0);
			idle();
		end
		$display("test protection done");
		erase(OP_BLK64, 24'h010000, 1'b1, 1'b1, 2'h1, 24'h010000);
		tx(32'(OP_SLEEP), 8, 0);
		tx({OP_WAKE_ID, 24'h0}, 32, 16);
		chk(32'(oe), 32'h0);
		repeat (SLEEP_ENTRY_CYC) @(posedge clk);
		chk(32'(asleep), 32'h0);
		idle();
		tx(32'({OP_SLEEP, 1'b0}), 9, 0);
		repeat (SLEEP_ENTRY_CYC) @(posedge clk);
		chk(32'(asleep), 32'h0);
		sleep();
		chk(32'(asleep), 32'h1);
		reg_chk(REG_STATUS, 32'h4, 1'b0);
		erase(OP_BLK64, 24'h0, 1'b1, 1'b0, 2'h1, 24'h0);
		tx(32'(OP_WAKE_ID), 8, 0);
		reg_chk(REG_STATUS, 32'h8, 1'b0);
		repeat (WAKE_CYC) @(posedge clk);
		chk(32'(asleep), 32'h0);
		reg_chk(REG_STATUS, 32'h0, 1'b0);
		$display("test power-down done");
		sleep();
		tx({OP_WAKE_ID, 24'h0}, 32, 16);
		chk(32'(rd), {16'h0, PART_ID, PART_ID});
		reg_chk(REG_STATUS, 32'h8, 1'b0);
		repeat (WAKE_ID_CYC) @(posedge clk);
		chk(32'(asleep), 32'h0);
		reg_chk(REG_STATUS, 32'h0, 1'b0);
		for (int i = 0; i < 2; i++) begin
			tx({OP_PAIR_ID, 24'(i)}, 32, 16);
			chk(32'(rd), i ? {16'h0, PART_ID, MAKER_ID} : {16'h0, MAKER_ID, PART_ID});
		end
		chk(32'(so_oe), 32'h0);
		sleep();
		tx(32'(OP_RST_EN), 8, 0);
		tx(32'(OP_RST), 8, 0);
		chk(32'(asleep), 32'h0);
		reg_chk(REG_STATUS, 32'h0, 1'b0);
		$display("test identification done");
		sleep();
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk(32'(asleep), 32'h0);
		reg_chk(REG_STATUS, 32'h0, 1'b0);
		chk(32'(exp_q.size()), 32'h0);
		$display("test restart done");
		summarize();
	end
endmodule : sfe_flash_cmd_tb_top
